// ### logic/dspwm_timer.sv
// Dual-slope phase and frequency correct 16-bit PWM timer
// Assumes a single-cycle byte register port on core_clk, no waits
//
// Functional notes
// - Shape select 8 uses capture top, 9 uses compare-A top.
// - Counter counts up from zero to top, then down to zero.
// - Counter holds top for exactly one tick before counting down.
// - Action 2 clears on up-match, sets on down-match; action 3 opposite.
// - Top values from three up to full 16-bit range are accepted.
// - Active compare values load from buffers only at bottom in shapes 8 and 9.
// - Wrap flag sets in the tick compares load, at bottom.
// - Compare-A or capture flag sets when counter reaches top.
// - Match flag sets when counter equals channel compare value.
// - Pin driven only when its direction bit selects output.
// - Compare at bottom gives steady low, at top high, non-inverting.
// - Tick is clock divided by 1, 8, 64, 256 or 1024.
// - All logic on core_clk; tick is only an enable.
// - 16-bit registers use byte access through shared high temp.
// - Low-byte write copies temp and low byte in one cycle.
// - Low-byte read captures the high byte into temp.
// - Compare reads return both bytes directly, temp untouched.
// - Action 0 disconnects; action 1 toggles A only with shape bit 3.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "dspwm_consts.svh"
module dspwm_timer
  import dspwm_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Register port
  input  wire dspwm_req_t   reg_req,
  output logic [7:0]        reg_rdata,
  // Waveform pins
  output logic              wave_output_a,
  output logic              wave_oe_a,
  output logic              wave_output_b,
  output logic              wave_oe_b,
  // Flag levels
  output dspwm_flags_t      flags
);

  ////////////////////////////////////////////////////////////////////
  logic [7:0]   ctrl_a_ff;
  logic [7:0]   ctrl_b_ff;
  logic [1:0]   pin_dir_ff;
  logic [7:0]   temp_ff;
  logic [7:0]   rdata_ff;
  logic [15:0]  count_value_ff;
  logic [15:0]  cmpa_buf_ff;
  logic [15:0]  cmpb_buf_ff;
  logic [15:0]  compare_value_a_ff;
  logic [15:0]  compare_value_b_ff;
  logic [15:0]  capture_value_ff;
  logic [9:0]   presc_ff;
  logic         tick_enable;
  dspwm_dir_t   dir_ff;
  dspwm_flags_t flags_ff;
  logic         wave_a_ff;
  logic         wave_b_ff;
  logic         oe_a_ff;
  logic         oe_b_ff;
  logic [9:0]   div_max;
  logic [3:0]   wave_shape_select;
  logic         wave_shape_top_bit;
  logic [1:0]   act_a;
  logic [1:0]   act_b;
  logic         pfc_mode;
  logic [15:0]  top_value;
  logic         step;
  logic         at_top;
  logic         at_bottom;
  logic         slope_up;
  logic         match_a;
  logic         match_b;
  logic         wr_en;
  logic         rd_en;
  logic [3:0]   addr;
  logic [7:0]   wdata;
  dspwm_flags_t flag_set;
  dspwm_flags_t flag_clr;

  assign addr               = reg_req.addr;
  assign wdata              = reg_req.wdata;
  assign wr_en              = reg_req.wr;
  assign rd_en              = reg_req.rd;
  assign act_a              = ctrl_a_ff[7:6];
  assign act_b              = ctrl_a_ff[5:4];
  assign wave_shape_select  = {ctrl_b_ff[4:3], ctrl_a_ff[1:0]};
  assign wave_shape_top_bit = wave_shape_select[3];
  assign pfc_mode = (wave_shape_select == `DSPWM_SHAPE_CAPT) ||
                    (wave_shape_select == `DSPWM_SHAPE_CMPA);
  assign top_value = (wave_shape_select == `DSPWM_SHAPE_CAPT) ?
                     capture_value_ff : compare_value_a_ff;
  assign step      = tick_enable && pfc_mode;
  assign at_top    = count_value_ff == top_value;
  assign at_bottom = count_value_ff == `DSPWM_ZERO16;
  // Bottom belongs to the up slope, top to the down slope
  assign slope_up  = at_bottom || ((dir_ff == DSPWM_UP) && !at_top);
  assign match_a   = step && (count_value_ff == compare_value_a_ff);
  assign match_b   = step && (count_value_ff == compare_value_b_ff);

  assign reg_rdata     = rdata_ff;
  assign wave_output_a = wave_a_ff;
  assign wave_output_b = wave_b_ff;
  assign wave_oe_a     = oe_a_ff;
  assign wave_oe_b     = oe_b_ff;
  assign flags         = flags_ff;

  ////////////////////////////////////////////////////////////////////
  // Prescaler
  always_comb
  begin
    case (ctrl_b_ff[2:0])
      3'h1:    div_max = `DSPWM_DIV1;
      3'h2:    div_max = `DSPWM_DIV8;
      3'h3:    div_max = `DSPWM_DIV64;
      3'h4:    div_max = `DSPWM_DIV256;
      3'h5:    div_max = `DSPWM_DIV1024;
      default: div_max = `DSPWM_DIV1;
    endcase
  end

  assign tick_enable = (ctrl_b_ff[2:0] != 3'h0) && (ctrl_b_ff[2:0] < 3'h6) &&
                       (presc_ff == div_max);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || tick_enable || (ctrl_b_ff[2:0] == 3'h0))
      presc_ff <= 10'h000;
    else
      presc_ff <= presc_ff + 10'h001;
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl_a_ff  <= `DSPWM_ZERO8;
      ctrl_b_ff  <= `DSPWM_ZERO8;
      pin_dir_ff <= 2'h0;
    end
    else if (wr_en)
    begin
      if (addr == `DSPWM_A_CTRL_A)
        ctrl_a_ff <= wdata;
      if (addr == `DSPWM_A_CTRL_B)
        ctrl_b_ff <= wdata;
      if (addr == `DSPWM_A_PIN_DIR)
        pin_dir_ff <= wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shared high-byte temporary
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      temp_ff <= `DSPWM_ZERO8;
    else if (wr_en && addr[0] && (addr >= `DSPWM_A_COUNT_H))
      temp_ff <= wdata;
    else if (rd_en && (addr == `DSPWM_A_COUNT_L))
      temp_ff <= count_value_ff[15:8];
    else if (rd_en && (addr == `DSPWM_A_CAPT_L))
      temp_ff <= capture_value_ff[15:8];
  end

  ////////////////////////////////////////////////////////////////////
  // Counter and direction
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      count_value_ff <= `DSPWM_ZERO16;
      dir_ff         <= DSPWM_UP;
    end
    else if (wr_en && (addr == `DSPWM_A_COUNT_L))
      count_value_ff <= {temp_ff, wdata};
    else if (step)
    begin
      case (dir_ff)
        DSPWM_UP:
        begin
          if (count_value_ff >= top_value)
          begin
            dir_ff         <= DSPWM_DOWN;
            count_value_ff <= count_value_ff - `DSPWM_ONE16;
          end
          else
            count_value_ff <= count_value_ff + `DSPWM_ONE16;
        end
        DSPWM_DOWN:
        begin
          if (at_bottom)
          begin
            dir_ff         <= DSPWM_UP;
            count_value_ff <= count_value_ff + `DSPWM_ONE16;
          end
          else
            count_value_ff <= count_value_ff - `DSPWM_ONE16;
        end
        default:
          dir_ff <= DSPWM_UP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Compare buffers, active compares and capture value
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmpa_buf_ff        <= `DSPWM_ZERO16;
      cmpb_buf_ff        <= `DSPWM_ZERO16;
      compare_value_a_ff <= `DSPWM_ZERO16;
      compare_value_b_ff <= `DSPWM_ZERO16;
      capture_value_ff   <= `DSPWM_ZERO16;
    end
    else
    begin
      if (wr_en && (addr == `DSPWM_A_CMPA_L))
        cmpa_buf_ff <= {temp_ff, wdata};
      if (wr_en && (addr == `DSPWM_A_CMPB_L))
        cmpb_buf_ff <= {temp_ff, wdata};
      if (wr_en && (addr == `DSPWM_A_CAPT_L))
        capture_value_ff <= {temp_ff, wdata};
      // Outside the dual-slope modes compares follow the buffer at once
      if ((step && at_bottom) || !pfc_mode)
      begin
        compare_value_a_ff <= cmpa_buf_ff;
        compare_value_b_ff <= cmpb_buf_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flags, write one to clear, set wins
  assign flag_set.wrap    = step && at_bottom;
  assign flag_set.match_a = match_a || (step && at_top &&
                            (wave_shape_select == `DSPWM_SHAPE_CMPA));
  assign flag_set.match_b = match_b;
  assign flag_set.capture = step && at_top &&
                            (wave_shape_select == `DSPWM_SHAPE_CAPT);
  assign flag_clr = (wr_en && (addr == `DSPWM_A_FLAGS)) ?
                    {wdata[`DSPWM_F_CAPTURE], wdata[`DSPWM_F_MATCH_B],
                     wdata[`DSPWM_F_MATCH_A], wdata[`DSPWM_F_WRAP]} : 4'h0;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flags_ff <= 4'h0;
    else
      flags_ff <= (flags_ff & ~flag_clr) | flag_set;
  end

  ////////////////////////////////////////////////////////////////////
  // Waveform outputs
  function automatic logic wave_next(input logic [1:0] act, input logic cur,
                                     input logic hit, input logic up,
                                     input logic tog_ok);
    logic res;
    res = cur;
    if (hit)
    begin
      case (act)
        `DSPWM_ACT_NONINV: res = !up;
        `DSPWM_ACT_INV:    res = up;
        `DSPWM_ACT_TOGGLE: res = tog_ok ? !cur : cur;
        default:           res = cur;
      endcase
    end
    return res;
  endfunction : wave_next

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wave_a_ff <= 1'b0;
      wave_b_ff <= 1'b0;
      oe_a_ff   <= 1'b0;
      oe_b_ff   <= 1'b0;
    end
    else
    begin
      wave_a_ff <= wave_next(act_a, wave_a_ff, match_a, slope_up,
                             wave_shape_top_bit);
      wave_b_ff <= wave_next(act_b, wave_b_ff, match_b, slope_up, 1'b0);
      oe_a_ff   <= pin_dir_ff[0] && (act_a != `DSPWM_ACT_OFF) &&
                   ((act_a != `DSPWM_ACT_TOGGLE) || wave_shape_top_bit);
      oe_b_ff   <= pin_dir_ff[1] && (act_b != `DSPWM_ACT_OFF) &&
                   (act_b != `DSPWM_ACT_TOGGLE);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !rd_en)
      rdata_ff <= `DSPWM_ZERO8;
    else
    begin
      case (addr)
        `DSPWM_A_CTRL_A:  rdata_ff <= ctrl_a_ff;
        `DSPWM_A_CTRL_B:  rdata_ff <= ctrl_b_ff;
        `DSPWM_A_FLAGS:   rdata_ff <= {2'h0, flags_ff.capture, 2'h0,
                                       flags_ff.match_b, flags_ff.match_a,
                                       flags_ff.wrap};
        `DSPWM_A_PIN_DIR: rdata_ff <= {6'h00, pin_dir_ff};
        `DSPWM_A_COUNT_L: rdata_ff <= count_value_ff[7:0];
        `DSPWM_A_COUNT_H: rdata_ff <= temp_ff;
        `DSPWM_A_CMPA_L:  rdata_ff <= cmpa_buf_ff[7:0];
        `DSPWM_A_CMPA_H:  rdata_ff <= cmpa_buf_ff[15:8];
        `DSPWM_A_CMPB_L:  rdata_ff <= cmpb_buf_ff[7:0];
        `DSPWM_A_CMPB_H:  rdata_ff <= cmpb_buf_ff[15:8];
        `DSPWM_A_CAPT_L:  rdata_ff <= capture_value_ff[7:0];
        `DSPWM_A_CAPT_H:  rdata_ff <= temp_ff;
        default:          rdata_ff <= `DSPWM_ZERO8;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  property p_top_turn;
    @(posedge core_clk) disable iff (sys_rst)
    (step && at_top && (dir_ff == DSPWM_UP) && !wr_en) |=> (dir_ff == DSPWM_DOWN);
  endproperty
  a_top_turn: assert property (p_top_turn) else $error("no turn at top");

  property p_bottom_turn;
    @(posedge core_clk) disable iff (sys_rst)
    (step && at_bottom && !wr_en) |=> (dir_ff == DSPWM_UP) &&
                                      (count_value_ff == `DSPWM_ONE16);
  endproperty
  a_bottom_turn: assert property (p_bottom_turn) else $error("bad bottom turn");

  property p_load_bottom;
    @(posedge core_clk) disable iff (sys_rst)
    (pfc_mode && !(step && at_bottom)) |=> $stable(compare_value_b_ff);
  endproperty
  a_load_bottom: assert property (p_load_bottom) else $error("compare moved");

  property p_wrap;
    @(posedge core_clk) disable iff (sys_rst)
    (step && at_bottom) |=> flags_ff.wrap && (compare_value_a_ff == $past(cmpa_buf_ff));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missed");

  property p_cap_flag;
    @(posedge core_clk) disable iff (sys_rst)
    (step && at_top && (wave_shape_select == `DSPWM_SHAPE_CAPT)) |=> flags_ff.capture;
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag missed");

  property p_match_b;
    @(posedge core_clk) disable iff (sys_rst)
    match_b |=> flags_ff.match_b;
  endproperty
  a_match_b: assert property (p_match_b) else $error("match flag missed");

  property p_noninv;
    @(posedge core_clk) disable iff (sys_rst)
    (match_b && (act_b == `DSPWM_ACT_NONINV)) |=> (wave_b_ff == !$past(slope_up));
  endproperty
  a_noninv: assert property (p_noninv) else $error("bad wave level");

  property p_pin_dir;
    @(posedge core_clk) disable iff (sys_rst)
    !pin_dir_ff[0] |=> !oe_a_ff;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin driven as input");

  property p_low_write;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_en && (addr == `DSPWM_A_COUNT_L)) |=>
      (count_value_ff == {$past(temp_ff), $past(wdata)});
  endproperty
  a_low_write: assert property (p_low_write) else $error("bad 16-bit write");

  property p_low_read;
    @(posedge core_clk) disable iff (sys_rst)
    (rd_en && (addr == `DSPWM_A_COUNT_L)) |=> (temp_ff == $past(count_value_ff[15:8]));
  endproperty
  a_low_read: assert property (p_low_read) else $error("temp not captured");

  property p_cmp_read;
    @(posedge core_clk) disable iff (sys_rst)
    (rd_en && (addr == `DSPWM_A_CMPA_L)) |=> $stable(temp_ff);
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("temp disturbed");

  c_top:    cover property (@(posedge core_clk) step && at_top && pfc_mode);
  c_wrap:   cover property (@(posedge core_clk) flag_set.wrap);
  c_wave_a: cover property (@(posedge core_clk) $rose(wave_a_ff));
  c_toggle: cover property (@(posedge core_clk) match_a && (act_a == `DSPWM_ACT_TOGGLE));

endmodule : dspwm_timer

// ### shared/dspwm_consts.svh
// Register map, field positions, reset values and prescaler counts
// Assumes inclusion by bare name from the timer package and logic
`ifndef DSPWM_CONSTS_SVH
`define DSPWM_CONSTS_SVH
`define DSPWM_A_CTRL_A   4'h0
`define DSPWM_A_CTRL_B   4'h1
`define DSPWM_A_FLAGS    4'h2
`define DSPWM_A_PIN_DIR  4'h3
`define DSPWM_A_COUNT_L  4'h4
`define DSPWM_A_COUNT_H  4'h5
`define DSPWM_A_CMPA_L   4'h6
`define DSPWM_A_CMPA_H   4'h7
`define DSPWM_A_CMPB_L   4'h8
`define DSPWM_A_CMPB_H   4'h9
`define DSPWM_A_CAPT_L   4'hA
`define DSPWM_A_CAPT_H   4'hB
`define DSPWM_F_WRAP     0
`define DSPWM_F_MATCH_A  1
`define DSPWM_F_MATCH_B  2
`define DSPWM_F_CAPTURE  5
`define DSPWM_SHAPE_CAPT 4'h8
`define DSPWM_SHAPE_CMPA 4'h9
`define DSPWM_ACT_OFF    2'h0
`define DSPWM_ACT_TOGGLE 2'h1
`define DSPWM_ACT_NONINV 2'h2
`define DSPWM_ACT_INV    2'h3
`define DSPWM_ZERO16     16'h0000
`define DSPWM_ONE16      16'h0001
`define DSPWM_ZERO8      8'h00
`define DSPWM_DIV1       10'h000
`define DSPWM_DIV8       10'h007
`define DSPWM_DIV64      10'h03F
`define DSPWM_DIV256     10'h0FF
`define DSPWM_DIV1024    10'h3FF
`endif

// ### shared/dspwm_pkg.sv
// Types shared by the dual-slope timer and its bench
// Assumes dspwm_consts.svh on the include path
`include "dspwm_consts.svh"
package dspwm_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dspwm_req_t;

  typedef struct packed {
    logic capture;
    logic match_b;
    logic match_a;
    logic wrap;
  } dspwm_flags_t;

  typedef enum logic {
    DSPWM_UP,
    DSPWM_DOWN
  } dspwm_dir_t;
endpackage : dspwm_pkg

// ### tb/dspwm_cpu_model.sv
// Processor-side model driving the timer's byte register port
// Assumes the timer samples strobes on rising core_clk and never waits
`timescale 1ns/1ps
module dspwm_cpu_model
  import dspwm_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output dspwm_req_t      reg_req,
  input  wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
  endtask : wr8

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd8

  ////////////////////////////////////////////////////////////////////////////
  // Pairs never interleaved; no interrupt code shares temp
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr8(a + 4'h1, v[15:8]);
    wr8(a, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 4'h1, v[15:8]);
  endtask : rd16
endmodule : dspwm_cpu_model

// ### tb/tb.sv
// Self-checking bench for the dual-slope PWM timer
// Assumes the cpu model in tb/ and the timer package on the path
`timescale 1ns/1ps
`include "dspwm_consts.svh"
module tb
  import dspwm_pkg::*;
;
  typedef struct {
    logic [15:0] top, ca, cb;
    logic [7:0]  ctl_a, ctl_b;
    int          win, ha, hb;
    logic [1:0]  oe;
  } dspwm_row_t;

  logic         core_clk = 1'b0;
  logic         sys_rst  = 1'b1;
  dspwm_req_t   reg_req;
  logic [7:0]   reg_rdata;
  logic         wave_output_a, wave_oe_a, wave_output_b, wave_oe_b;
  dspwm_flags_t flags;
  int           bad_count = 0;
  int           checks    = 0;
  int           cycles    = 0;
  int           ha, hb, ok, m;
  logic [15:0]  v;
  logic [7:0]   b;
  logic [15:0]  samp [8];
  // Top never below any compare value
  dspwm_row_t   rows [6] = '{
    '{16'h0010, 16'h0004, 16'h000A, 8'hB0, 8'h11, 32, 8, 12, 2'b11},
    '{16'h0003, 16'h0000, 16'h0003, 8'hA0, 8'h11, 6, 0, 6, 2'b11},
    '{16'h0003, 16'h0000, 16'h0003, 8'hF0, 8'h11, 6, 6, 0, 2'b11},
    '{16'h0005, 16'h0002, 16'h0005, 8'hA0, 8'h12, 80, 32, 80, 2'b11},
    '{16'h0006, 16'h0006, 16'h0002, 8'h61, 8'h11, 24, 12, 8, 2'b11},
    '{16'h0004, 16'h0002, 16'h0002, 8'h10, 8'h11, 8, 0, 0, 2'b00}};

  always #25 core_clk = ~core_clk;

  dspwm_timer i_dspwm_timer (.core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .wave_output_a(wave_output_a), .wave_oe_a(wave_oe_a),
    .wave_output_b(wave_output_b), .wave_oe_b(wave_oe_b), .flags(flags));

  dspwm_cpu_model i_dspwm_cpu_model (.core_clk(core_clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : cmp8

  task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : cmp16

  task automatic cmp_int(input string n, input int e, input int g);
    checks++;
    if (g != e)
    begin
      bad_count++;
      $display("FAIL %s expected %0d seen %0d", n, e, g);
    end
  endtask : cmp_int

  // High cycles of each output over a window, phase independent
  task automatic measure(input int win, output int a, output int c);
    a = 0;
    c = 0;
    repeat (win)
    begin
      @(posedge core_clk);
      a += int'(wave_output_a === 1'b1);
      c += int'(wave_output_b === 1'b1);
    end
  endtask : measure

  function automatic int walk(input int k);
    int j;
    j = k % 6;
    return (j <= 3) ? j : 6 - j;
  endfunction : walk

  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    cmp8("reset outs", 8'h00, {2'b00, flags, wave_oe_b, wave_oe_a});
    i_dspwm_cpu_model.wr8(`DSPWM_A_PIN_DIR, 8'h03);
    foreach (rows[i])
    begin
      i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
      i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_A, rows[i].ctl_a);
      i_dspwm_cpu_model.wr16(`DSPWM_A_COUNT_L, 16'h0000);
      i_dspwm_cpu_model.wr16(`DSPWM_A_CAPT_L, rows[i].top);
      i_dspwm_cpu_model.wr16(`DSPWM_A_CMPA_L, rows[i].ca);
      i_dspwm_cpu_model.wr16(`DSPWM_A_CMPB_L, rows[i].cb);
      i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, rows[i].ctl_b);
      repeat (2 * rows[i].win) @(posedge core_clk);
      measure(rows[i].win, ha, hb);
      cmp8("pin enables", {6'h00, rows[i].oe}, {6'h00, wave_oe_b, wave_oe_a});
      if (rows[i].oe[0])
        cmp_int("high a", rows[i].ha, ha);
      if (rows[i].oe[1])
        cmp_int("high b", rows[i].hb, hb);
      $display("test row %0d done", i);
    end
    // Pin direction gates the drivers
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_A, 8'hA0);
    i_dspwm_cpu_model.wr8(`DSPWM_A_PIN_DIR, 8'h00);
    repeat (3) @(posedge core_clk);
    cmp8("enables dir 0", 8'h00, {6'h00, wave_oe_b, wave_oe_a});
    i_dspwm_cpu_model.wr8(`DSPWM_A_PIN_DIR, 8'h02);
    repeat (3) @(posedge core_clk);
    cmp8("enables dir 2", 8'h02, {6'h00, wave_oe_b, wave_oe_a});
    $display("test pin direction done");
    // Byte access through the shared high temp
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
    i_dspwm_cpu_model.wr16(`DSPWM_A_COUNT_L, 16'h01FF);
    i_dspwm_cpu_model.rd16(`DSPWM_A_COUNT_L, v);
    cmp16("count", 16'h01FF, v);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CAPT_L, 16'h1234);
    i_dspwm_cpu_model.rd16(`DSPWM_A_CAPT_L, v);
    cmp16("capture", 16'h1234, v);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CMPA_L, 16'hBEEF);
    i_dspwm_cpu_model.rd8(`DSPWM_A_COUNT_L, b);
    i_dspwm_cpu_model.rd16(`DSPWM_A_CMPA_L, v);
    cmp16("compare a", 16'hBEEF, v);
    i_dspwm_cpu_model.rd8(`DSPWM_A_COUNT_H, b);
    cmp8("temp kept", 8'h01, b);
    i_dspwm_cpu_model.wr8(`DSPWM_A_COUNT_H, 8'hAB);
    i_dspwm_cpu_model.rd8(`DSPWM_A_COUNT_H, b);
    cmp8("temp read", 8'hAB, b);
    i_dspwm_cpu_model.wr8(4'hC, 8'h5A);
    i_dspwm_cpu_model.rd8(4'hC, b);
    cmp8("unmapped", 8'h00, b);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_A, 8'h00);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h01);
    repeat (20) @(posedge core_clk);
    i_dspwm_cpu_model.rd16(`DSPWM_A_COUNT_L, v);
    cmp16("count held", 16'h01FF, v);
    $display("test byte access done");
    // Count walk sampled once per tick at divide by 8
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CAPT_L, 16'h0003);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CMPA_L, 16'h0001);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CMPB_L, 16'h0002);
    i_dspwm_cpu_model.wr16(`DSPWM_A_COUNT_L, 16'h0000);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h12);
    for (int i = 0; i < 8; i++)
    begin
      i_dspwm_cpu_model.rd16(`DSPWM_A_COUNT_L, samp[i]);
      repeat (2) @(posedge core_clk);
    end
    ok = 0;
    for (int s = 0; s < 6; s++)
    begin
      m = 1;
      for (int i = 0; i < 8; i++)
        if (samp[i] !== 16'(walk(s + i)))
          m = 0;
      ok |= m;
    end
    cmp_int("count walk", 1, ok);
    $display("test count walk done");
    // Flags with capture top, then compare-A top
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
    i_dspwm_cpu_model.wr8(`DSPWM_A_FLAGS, 8'hFF);
    i_dspwm_cpu_model.rd8(`DSPWM_A_FLAGS, b);
    cmp8("flags cleared", 8'h00, b);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h11);
    repeat (20) @(posedge core_clk);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
    i_dspwm_cpu_model.rd8(`DSPWM_A_FLAGS, b);
    cmp8("flags capture top", 8'h27, b);
    cmp8("flag port", 8'h0F, {4'h0, flags});
    i_dspwm_cpu_model.wr8(`DSPWM_A_FLAGS, 8'hFF);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_A, 8'h01);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CMPA_L, 16'h0003);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h11);
    repeat (20) @(posedge core_clk);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
    i_dspwm_cpu_model.rd8(`DSPWM_A_FLAGS, b);
    cmp8("flags compare top", 8'h07, b);
    $display("test flags done");
    // Slow prescaler settings, stopped halfway through the third tick
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_A, 8'h00);
    i_dspwm_cpu_model.wr16(`DSPWM_A_CAPT_L, 16'hFFFF);
    for (int k = 3; k < 6; k++)
    begin
      i_dspwm_cpu_model.wr16(`DSPWM_A_COUNT_L, 16'h0000);
      i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10 | 8'(k));
      repeat ((5 << (2 * k - 1)) - 2) @(posedge core_clk);
      i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h10);
      i_dspwm_cpu_model.rd16(`DSPWM_A_COUNT_L, v);
      cmp16("slow count", 16'h0002, v);
    end
    $display("test slow prescale done");
    // Reset in mid-run clears counter, flags, control and pins
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_A, 8'hA0);
    i_dspwm_cpu_model.wr8(`DSPWM_A_CTRL_B, 8'h11);
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    cmp8("reset mid outs", 8'h00, {flags, wave_output_b, wave_output_a, wave_oe_b, wave_oe_a});
    i_dspwm_cpu_model.rd16(`DSPWM_A_COUNT_L, v);
    cmp16("reset mid count", 16'h0000, v);
    i_dspwm_cpu_model.rd8(`DSPWM_A_CTRL_B, b);
    cmp8("reset mid ctrl", 8'h00, b);
    $display("test reset done");
    complete_run();
  end
endmodule : tb
